// *** rtl/sfrw_defines.svh ***
`ifndef SFRW_DEFINES_SVH
`define SFRW_DEFINES_SVH
`define SFRW_OP_SET_WRAP   8'h77
`define SFRW_OP_SET_PARAM  8'hC0
`define SFRW_OP_FRQIO      8'hEB
`define SFRW_OP_FRQIO4B    8'hEC
`define SFRW_OP_DTRQIO     8'hED
`define SFRW_OP_FAST       8'h0B
`define SFRW_OP_DTRFAST    8'h0D
`define SFRW_OP_BURSTWRAP  8'h0C
`define SFRW_OP_DTRBURST   8'h0E
`define SFRW_WRAP_RESET    8'h10
`define SFRW_PARAM_RESET   8'h00
`define SFRW_WRAP_DIS_BIT  4
`define SFRW_WRAP_LEN_HI   6
`define SFRW_WRAP_LEN_LO   5
`define SFRW_PAR_DUM_HI    6
`define SFRW_PAR_DUM_LO    4
`define SFRW_PAR_WL_HI     1
`define SFRW_PAR_WL_LO     0
`define SFRW_FIXED_DUMMY   5'h08
`endif

// *** rtl/sfrw_pkg.sv ***
package sfrw_pkg;
  typedef enum logic [1:0] {
    SFRW_CMD  = 2'b00,
    SFRW_ADDR = 2'b01,
    SFRW_ARG  = 2'b10,
    SFRW_DATA = 2'b11
  } sfrw_state_e;
  typedef struct packed {
    logic [7:0] wrap_bits;
    logic [7:0] param;
  } sfrw_cfg_s;
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        wrap;
    logic [7:0]  wrap_len;
    logic [4:0]  dummy;
  } sfrw_read_s;
endpackage

// *** rtl/sfrw_core.sv ***
// Function
// RQ1 - ECh always takes a 32-bit address
// RQ2 - ECh accepted only in single-line mode
// RQ3 - ECh defaults to six dummy clocks
// RQ4 - Wrapping reads stay inside aligned section
// RQ5 - 77h: opcode, 24/32 dummy, wrap byte
// RQ6 - Wrap bit 4 low enables, 6..5 length
// RQ7 - Wrap setting applies to later quad reads
// RQ8 - Reset sets wrap disable bit
// RQ9 - Wrap bits only in single-line mode
// RQ10 - Parameter register: dummy and wrap fields
// RQ11 - Single-line C0h writes only dummy field
// RQ12 - Dummy field governs listed read opcodes
// RQ13 - Quad mode wrap length for 0Ch/0Eh
// RQ14 - Quad mode plain reads never wrap
// RQ15 - Other fast reads use fixed dummy
// RQ16 - Settings kept across mode switches
// RQ17 - Reset clears parameter register
// RQ18 - Single-line EBh/ECh dummy mapping
// RQ19 - Quad mode 0Bh/EBh/0Ch dummy mapping
// RQ20 - Single-line EDh dummy mapping
// RQ21 - Quad double-rate dummy mapping
// RQ22 - Host configures before configurable reads
// RQ23 - Mode bits count within dummy clocks
// RQ24 - Wrap counter increments only low bits
`timescale 1ns/10ps
`include "sfrw_defines.svh"
module sfrw_core (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic [3:0]           io_in,
  input  wire logic                 quad_command_mode,
  input  wire logic                 addr4_mode,
  input  wire logic                 soft_reset,
  input  wire logic                 data_beat,
  output sfrw_pkg::sfrw_cfg_s       cfg,
  output sfrw_pkg::sfrw_read_s      rd,
  output logic      [31:0]          cur_addr
);
  import sfrw_pkg::*;

  // Link domain: shift in on sck rising edge, framed by cs_n
  sfrw_state_e st;
  logic [5:0]  bitcnt;
  logic [31:0] sh;
  logic [7:0]  op;
  logic        lk_wr_wrap;
  logic        lk_wr_par;
  logic [7:0]  lk_arg;
  logic        lk_rd;
  logic [31:0] lk_addr;
  logic        lk_mode;
  logic        lk_tgl;
  logic        lk_rd_tgl;

  function automatic logic [5:0] lanes(input logic q, input logic quadwide);
    lanes = (q || quadwide) ? 6'd4 : 6'd1;
  endfunction

  function automatic logic is_read(input logic [7:0] o, input logic q);
    if (q) begin
      is_read = (o == `SFRW_OP_FAST) || (o == `SFRW_OP_FRQIO) || (o == `SFRW_OP_BURSTWRAP) ||
                (o == `SFRW_OP_DTRFAST) || (o == `SFRW_OP_DTRQIO) || (o == `SFRW_OP_DTRBURST);
    end else begin
      // ECh refused in quad mode
      is_read = (o == `SFRW_OP_FRQIO) || (o == `SFRW_OP_FRQIO4B) || (o == `SFRW_OP_DTRQIO); // RQ2
    end
  endfunction

  logic [7:0] next_byte;
  logic [3:0] q_s;
  assign q_s = io_in;
  always_comb begin
    next_byte = quad_command_mode ? {sh[3:0], q_s} : {sh[6:0], q_s[0]};
  end

  // Address length per opcode
  function automatic logic [5:0] addr_bits(input logic [7:0] o, input logic a4);
    if (o == `SFRW_OP_FRQIO4B) begin
      addr_bits = 6'd32; // RQ1
    end else begin
      addr_bits = a4 ? 6'd32 : 6'd24; // RQ5
    end
  endfunction

  // Frame state also clears on rst_n so the first frame never starts from an unknown state
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (cs_n || !rst_n) begin
      st     <= SFRW_CMD;
      bitcnt <= 6'd0;
      sh     <= 32'h0000_0000;
      op     <= 8'h00;
    end else begin
      unique case (st)
        SFRW_CMD: begin
          sh     <= {24'h00_0000, next_byte};
          bitcnt <= bitcnt + lanes(quad_command_mode, 1'b0);
          if (bitcnt + lanes(quad_command_mode, 1'b0) >= 6'd8) begin
            op     <= next_byte;
            st     <= SFRW_ADDR;
            bitcnt <= 6'd0;
          end
        end
        SFRW_ADDR: begin
          sh     <= {sh[27:0], (op == `SFRW_OP_SET_WRAP && !quad_command_mode) ?
                     {3'b000, q_s[0]} : q_s};
          bitcnt <= bitcnt + ((op == `SFRW_OP_SET_WRAP && !quad_command_mode) ? 6'd1 : 6'd4);
          if (op == `SFRW_OP_SET_PARAM) begin
            st <= SFRW_ARG;
            sh <= {28'h000_0000, quad_command_mode ? q_s : {3'b000, q_s[0]}};
            bitcnt <= lanes(quad_command_mode, 1'b0);
          end else if (bitcnt + ((op == `SFRW_OP_SET_WRAP && !quad_command_mode) ? 6'd1 : 6'd4)
                       >= addr_bits(op, addr4_mode)) begin
            st     <= (op == `SFRW_OP_SET_WRAP) ? SFRW_ARG : SFRW_DATA;
            bitcnt <= 6'd0;
          end
        end
        SFRW_ARG: begin
          sh     <= quad_command_mode ? {sh[27:0], q_s} : {sh[30:0], q_s[0]};
          bitcnt <= bitcnt + lanes(quad_command_mode, 1'b0);
          if (bitcnt + lanes(quad_command_mode, 1'b0) >= 6'd8) begin
            st <= SFRW_DATA;
          end
        end
        SFRW_DATA: begin
          bitcnt <= bitcnt;
        end
        default: st <= SFRW_CMD;
      endcase
    end
  end

  // Capture config writes at end of argument and reads at end of address; toggles carry events across
  logic [7:0] arg_byte;
  always_comb begin
    arg_byte = quad_command_mode ? {sh[3:0], q_s} : {sh[6:0], q_s[0]};
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lk_wr_wrap <= 1'b0;
      lk_wr_par  <= 1'b0;
      lk_arg     <= 8'h00;
      lk_tgl     <= 1'b0;
      lk_rd      <= 1'b0;
      lk_addr    <= 32'h0000_0000;
      lk_mode    <= 1'b0;
      lk_rd_tgl  <= 1'b0;
    end else if (!cs_n) begin
      if (st == SFRW_ARG && bitcnt + lanes(quad_command_mode, 1'b0) >= 6'd8) begin
        lk_arg     <= arg_byte;
        lk_wr_wrap <= (op == `SFRW_OP_SET_WRAP) && !quad_command_mode; // RQ5
        lk_wr_par  <= (op == `SFRW_OP_SET_PARAM);
        lk_mode    <= quad_command_mode;
        lk_tgl     <= ~lk_tgl;
      end
      if (st == SFRW_ADDR && op != `SFRW_OP_SET_PARAM && op != `SFRW_OP_SET_WRAP &&
          bitcnt + 6'd4 >= addr_bits(op, addr4_mode) && is_read(op, quad_command_mode)) begin
        lk_addr   <= addr_bits(op, addr4_mode) == 6'd32 ? {sh[27:0], q_s} :
                     {8'h00, sh[19:0], q_s};
        lk_rd     <= 1'b1;
        lk_mode   <= quad_command_mode;
        lk_rd_tgl <= ~lk_rd_tgl;
      end
    end
  end

  // Opcode is stable once a frame reached argument or data state
  logic [7:0] lk_op;
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lk_op <= 8'h00;
    end else if (!cs_n && st == SFRW_ADDR && bitcnt == 6'd0) begin
      lk_op <= op;
    end
  end

  // Core domain crossing: toggles pass two flops, data is quiet by then
  logic [2:0] tg_s;
  logic [2:0] rt_s;
  logic [1:0] cs_s;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tg_s <= 3'b000;
      rt_s <= 3'b000;
      cs_s <= 2'b11;
    end else begin
      tg_s <= {tg_s[1:0], lk_tgl};
      rt_s <= {rt_s[1:0], lk_rd_tgl};
      cs_s <= {cs_s[0], cs_n};
    end
  end
  logic cfg_ev;
  logic rd_ev;
  assign cfg_ev = tg_s[2] ^ tg_s[1];
  assign rd_ev  = rt_s[2] ^ rt_s[1];

  // Configuration registers; never touched by mode switch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.wrap_bits <= `SFRW_WRAP_RESET; // RQ8
      cfg.param     <= `SFRW_PARAM_RESET; // RQ17
    end else if (soft_reset) begin
      cfg.wrap_bits <= `SFRW_WRAP_RESET; // RQ8
      cfg.param     <= `SFRW_PARAM_RESET; // RQ17
    end else if (cfg_ev) begin // RQ16
      if (lk_wr_wrap) begin
        cfg.wrap_bits <= {1'b0, lk_arg[6:4], 4'h0}; // RQ5
      end
      if (lk_wr_par) begin
        cfg.param[`SFRW_PAR_DUM_HI:`SFRW_PAR_DUM_LO] <= lk_arg[6:4]; // RQ10
        if (lk_mode) begin
          cfg.param[`SFRW_PAR_WL_HI:`SFRW_PAR_WL_LO] <= lk_arg[1:0]; // RQ11
        end
      end
    end
  end

  function automatic logic [7:0] len_of(input logic [1:0] s);
    len_of = 8'h08 << s; // RQ6
  endfunction

  function automatic logic [4:0] dummy_of(input logic [7:0] o, input logic q, input logic [2:0] p);
    logic [4:0] lin;
    lin = {1'b0, p, 1'b0} + 5'd2;
    if (q && (o == `SFRW_OP_FAST || o == `SFRW_OP_FRQIO || o == `SFRW_OP_BURSTWRAP)) begin
      dummy_of = lin; // RQ19
    end else if (o == `SFRW_OP_DTRQIO || o == `SFRW_OP_DTRFAST || o == `SFRW_OP_DTRBURST) begin
      dummy_of = (p < 3'd4) ? 5'd8 : lin; // RQ20 RQ21
    end else if (!q && (o == `SFRW_OP_FRQIO || o == `SFRW_OP_FRQIO4B)) begin
      dummy_of = (p < 3'd3) ? 5'd6 : lin; // RQ3 RQ18
    end else begin
      dummy_of = `SFRW_FIXED_DUMMY; // RQ15
    end
  endfunction

  // Read descriptor: dummy count includes mode bits in quad mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd <= '0;
    end else if (cs_s[1]) begin
      rd.valid <= 1'b0;
    end else if (rd_ev && lk_rd) begin
      rd.valid <= 1'b1;
      rd.addr  <= lk_addr;
      rd.dummy <= dummy_of(lk_op, lk_mode, cfg.param[6:4]); // RQ12 RQ23
      if (lk_mode) begin
        rd.wrap     <= (lk_op == `SFRW_OP_BURSTWRAP) || (lk_op == `SFRW_OP_DTRBURST); // RQ13 RQ14
        rd.wrap_len <= len_of(cfg.param[1:0]); // RQ13
      end else begin
        rd.wrap     <= !cfg.wrap_bits[`SFRW_WRAP_DIS_BIT]; // RQ7 RQ9
        rd.wrap_len <= len_of(cfg.wrap_bits[6:5]); // RQ6
      end
    end
  end

  // Wrapping counter keeps upper bits fixed
  logic [7:0] msk;
  assign msk = rd.wrap_len - 8'h01;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_addr <= 32'h0000_0000;
    end else if (rd_ev) begin
      cur_addr <= lk_addr;
    end else if (rd.valid && data_beat) begin
      if (rd.wrap) begin
        cur_addr[7:0] <= (cur_addr[7:0] & ~msk) | ((cur_addr[7:0] + 8'h01) & msk); // RQ4 RQ24
      end else begin
        cur_addr <= cur_addr + 32'h0000_0001; // RQ14
      end
    end
  end

  // Steps of a read: descriptor load, then byte beats
  sequence s_load;
    rd_ev && lk_rd && !cs_s[1];
  endsequence

  sequence s_beat_wrap;
    rd.valid && rd.wrap && data_beat && !rd_ev;
  endsequence

  sequence s_beat_lin;
    rd.valid && !rd.wrap && data_beat && !rd_ev;
  endsequence

  property p_wrap_stays;
    @(posedge core_clk) disable iff (!rst_n)
      s_beat_wrap |=>
        (cur_addr & ~{24'h00_0000, msk}) == ($past(cur_addr) & ~{24'h00_0000, msk});
  endproperty
  a_wrap_stays: assert property (p_wrap_stays) // RQ4
    else $error("wrap left section");

  property p_reset_dflt;
    @(posedge core_clk) soft_reset && rst_n |=> cfg.wrap_bits[4] && cfg.param == 8'h00;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) // RQ8
    else $error("reset did not restore defaults");

  property p_linear;
    @(posedge core_clk) disable iff (!rst_n)
      s_beat_lin |=> cur_addr == $past(cur_addr) + 32'h0000_0001;
  endproperty
  a_linear: assert property (p_linear) // RQ14
    else $error("linear step wrong");

  property p_cs_drop;
    @(posedge core_clk) disable iff (!rst_n)
      cs_s[1] |=> !rd.valid;
  endproperty
  a_cs_drop: assert property (p_cs_drop) // RQ4
    else $error("read stayed valid after frame end");

  property p_cfg_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      !cfg_ev && !soft_reset |=> $stable(cfg);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) // RQ16
    else $error("settings changed without a command");

  property p_wrap_clean;
    @(posedge core_clk) disable iff (!rst_n)
      cfg_ev && lk_wr_wrap && !soft_reset |=>
        cfg.wrap_bits[7] == 1'b0 && cfg.wrap_bits[3:0] == 4'h0;
  endproperty
  a_wrap_clean: assert property (p_wrap_clean) // RQ5
    else $error("unused wrap bits stored");

  property p_quad_len_kept;
    @(posedge core_clk) disable iff (!rst_n)
      cfg_ev && lk_wr_par && !lk_mode && !soft_reset |=> $stable(cfg.param[1:0]);
  endproperty
  a_quad_len_kept: assert property (p_quad_len_kept) // RQ11
    else $error("single-line write changed quad wrap length");

  property p_load_addr;
    @(posedge core_clk) disable iff (!rst_n)
      s_load |=> rd.valid && rd.addr == $past(lk_addr) && cur_addr == $past(lk_addr);
  endproperty
  a_load_addr: assert property (p_load_addr) // RQ1
    else $error("read address not loaded");

  property p_spi_dummy;
    @(posedge core_clk) disable iff (!rst_n)
      s_load ##0 (!lk_mode && (lk_op == `SFRW_OP_FRQIO || lk_op == `SFRW_OP_FRQIO4B) &&
                  cfg.param[6:4] < 3'd3) |=> rd.dummy == 5'd6;
  endproperty
  a_spi_dummy: assert property (p_spi_dummy) // RQ3
    else $error("single-line quad read dummy count wrong");

  property p_dtr_dummy;
    @(posedge core_clk) disable iff (!rst_n)
      s_load ##0 ((lk_op == `SFRW_OP_DTRQIO || lk_op == `SFRW_OP_DTRFAST ||
                   lk_op == `SFRW_OP_DTRBURST) && cfg.param[6:4] < 3'd4) |=> rd.dummy == 5'd8;
  endproperty
  a_dtr_dummy: assert property (p_dtr_dummy) // RQ21
    else $error("double-rate dummy count wrong");

  property p_qpi_nowrap;
    @(posedge core_clk) disable iff (!rst_n)
      s_load ##0 (lk_mode && lk_op != `SFRW_OP_BURSTWRAP && lk_op != `SFRW_OP_DTRBURST)
        |=> !rd.wrap;
  endproperty
  a_qpi_nowrap: assert property (p_qpi_nowrap) // RQ14
    else $error("plain quad-mode read wraps");

  property p_qpi_wrap;
    @(posedge core_clk) disable iff (!rst_n)
      s_load ##0 (lk_mode && (lk_op == `SFRW_OP_BURSTWRAP || lk_op == `SFRW_OP_DTRBURST))
        |=> rd.wrap;
  endproperty
  a_qpi_wrap: assert property (p_qpi_wrap) // RQ13
    else $error("quad-mode wrapping read does not wrap");

  property p_spi_wrap_off;
    @(posedge core_clk) disable iff (!rst_n)
      s_load ##0 (!lk_mode && cfg.wrap_bits[4]) |=> !rd.wrap;
  endproperty
  a_spi_wrap_off: assert property (p_spi_wrap_off) // RQ7
    else $error("wrap active while disabled");
endmodule

// *** dv/sfrw_host.sv ***
`timescale 1ns/10ps
module sfrw_host (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    io   = 4'h0;
  end
  // Left-aligned value, MSB first; a quad lane width puts the high nibble first
  task automatic put(input logic [39:0] v, input int n, input int w);
    for (int k = 0; k < n; k += w) begin
      io = (w == 4) ? v[39:36] : {~io[3:1], v[39]};
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
      v = v << w;
    end
  endtask
  // Clock stands still between frames; the frame stays open until stop
  task automatic frame(input logic [7:0] op, input int ow, input logic [39:0] pl,
                       input int nb, input int pw);
    cs_n = 1'b0;
    put({op, 32'h0000_0000}, 8, ow);
    put(pl, nb, pw);
  endtask
  task automatic stop();
    // Released lanes must not keep showing the last bits
    io   = ~io;
    cs_n = 1'b1;
    #500;
  endtask
endmodule

// *** dv/serial_flash_read_param_wrap_tb.sv ***
`timescale 1ns/10ps
`include "sfrw_defines.svh"
module serial_flash_read_param_wrap_tb;
  import sfrw_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        sck, cs_n, qm, a4, sr, db;
  logic [3:0]  io;
  sfrw_cfg_s   cfg;
  sfrw_read_s  rd;
  logic [31:0] cur_addr, a, ea;
  logic [15:0] sv;
  logic [7:0]  w, p;
  int          num_errors = 0, checks_done = 0, cycles = 0, nb;
  always #4 core_clk = ~core_clk;
  sfrw_host h (.sck(sck), .cs_n(cs_n), .io(io));
  sfrw_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .io_in(io),
    .quad_command_mode(qm), .addr4_mode(a4), .soft_reset(sr), .data_beat(db), .cfg(cfg),
    .rd(rd), .cur_addr(cur_addr));
  function automatic logic [4:0] spi_dum(input logic [2:0] c);
    return (c < 3) ? 5'h06 : 5'(2 * c + 2);
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] s, input logic wr, input int l,
                                      input int n);
    return wr ? ((s & ~32'(l - 1)) | ((s + n) & 32'(l - 1))) : s + n;
  endfunction
  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Address goes on four lanes; frame left open so the decoded read is visible
  task automatic rdf(input logic [7:0] op, input int ow);
    a  = $urandom;
    ea = (nb == 32) ? a : {8'h00, a[23:0]};
    h.frame(op, ow, 40'({a, 8'h00}) << (32 - nb), nb, 4);
    cyc(6);
  endtask
  task automatic rchk(input logic v, input logic wr, input int l, input logic [4:0] d);
    chk(rd.valid, v, "valid");
    if (v) begin
      chk(rd.addr, ea, "addr");
      chk(rd.wrap, wr, "wrap");
      chk(rd.dummy, d, "dummy");
      if (wr) chk(rd.wrap_len, l, "wrap_len");
      repeat (l + 3) begin
        db = 1'b1;
        cyc(1);
        db = 1'b0;
        cyc(1);
      end
      chk(cur_addr, nxt(ea, wr, l, l + 3), "cur_addr");
    end
    h.stop();
  endtask
  task automatic setw(input logic [7:0] wb, input int ow);
    h.frame(`SFRW_OP_SET_WRAP, ow, 40'(wb) << (a4 ? 0 : 8), a4 ? 40 : 32, ow);
    h.stop();
  endtask
  task automatic setp(input logic [7:0] pv, input int ow);
    h.frame(`SFRW_OP_SET_PARAM, ow, {pv, 32'h0000_0000}, 8, ow);
    h.stop();
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {qm, a4, sr, db} = 4'h0;
    rst_n = 1'b0;
    void'($urandom(32'h3328_eb8a));
    cyc(6);
    rst_n = 1'b1;
    cyc(3);
    chk(cfg, 16'h1000, "cfg reset");
    nb = 32;
    rdf(`SFRW_OP_FRQIO4B, 1);
    rchk(1'b1, 1'b0, 8, 5'h06);
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      w[6:5] = i[1:0];
      w[4] = i[2];
      a4 = $urandom;
      setw(w, 1);
      chk(cfg.wrap_bits, {1'b0, w[6:4], 4'h0}, "wrap bits");
      nb = a4 ? 32 : 24;
      rdf(`SFRW_OP_FRQIO, 1);
      rchk(1'b1, ~w[4], 8 << w[6:5], 5'h06);
    end
    a4 = 1'b0;
    for (int c = 0; c < 8; c++) begin
      p = $urandom;
      p[6:4] = c[2:0];
      setp(p, 1);
      chk(cfg.param[6:4], c[2:0], "dummy field");
      chk(cfg.param[1:0], 2'h0, "quad length kept");
      nb = 32;
      rdf(`SFRW_OP_FRQIO4B, 1);
      rchk(1'b1, 1'b0, 8, spi_dum(c[2:0]));
      nb = 24;
      rdf(`SFRW_OP_DTRQIO, 1);
      rchk(1'b1, 1'b0, 8, (c < 4) ? 5'h08 : 5'(2 * c + 2));
    end
    setw(8'h20, 1);
    sv = cfg;
    cyc(1);
    qm = 1'b1;
    cyc(4);
    chk(cfg, sv, "cfg to quad");
    nb = 24;
    for (int c = 0; c < 8; c++) begin
      p = $urandom;
      p[6:4] = c[2:0];
      setp(p, 4);
      chk({cfg.param[6:4], cfg.param[1:0]}, {p[6:4], p[1:0]}, "param");
      rdf(`SFRW_OP_FAST, 4);
      rchk(1'b1, 1'b0, 8, 5'(2 * c + 2));
      rdf(`SFRW_OP_BURSTWRAP, 4);
      rchk(1'b1, 1'b1, 8 << p[1:0], 5'(2 * c + 2));
      rdf(`SFRW_OP_FRQIO, 4);
      rchk(1'b1, 1'b0, 8, 5'(2 * c + 2));
      rdf(`SFRW_OP_DTRBURST, 4);
      rchk(1'b1, 1'b1, 8 << p[1:0], (c < 4) ? 5'h08 : 5'(2 * c + 2));
    end
    sv = cfg;
    nb = 32;
    rdf(`SFRW_OP_FRQIO4B, 4);
    rchk(1'b0, 1'b0, 8, 5'h00);
    setw(8'h00, 4);
    chk(cfg, sv, "wrap setup in quad");
    cyc(1);
    qm = 1'b0;
    cyc(4);
    chk(cfg, sv, "cfg to single");
    sr = 1'b1;
    cyc(1);
    sr = 1'b0;
    cyc(3);
    chk(cfg, 16'h1000, "soft reset");
    wrap_up();
  end
endmodule
